/* File: fmsc_defines.svh */
/*
 * constants for the float mode slot configuration bank: offsets, field
 * positions, reset values and timing counts.
 * assumes a 50 MHz sequencing clock and 8-bit register addresses.
 */
`ifndef FMSC_DEFINES_SVH
`define FMSC_DEFINES_SVH

// ==========================================================
// register port
`define FMSC_ADDR_W          8
`define FMSC_DATA_W          16
`define FMSC_OFF_CFG_B       8'h59
`define FMSC_OFF_FIRE        8'h5A
`define FMSC_OFF_CFG_A       8'h5E
`define FMSC_RST_CFG         16'h0808
`define FMSC_RST_FIRE        16'h0010
`define FMSC_RDATA_IDLE      16'h0000

// ==========================================================
// field positions
`define FMSC_EN_MSB          14
`define FMSC_EN_LSB          13
`define FMSC_PRE_MSB         12
`define FMSC_PRE_LSB         8
`define FMSC_FIRE_B_MSB      15
`define FMSC_FIRE_B_LSB      12
`define FMSC_FIRE_A_MSB      11
`define FMSC_FIRE_A_LSB      8

// ==========================================================
// encodings
`define FMSC_EN_ON           2'h3
`define FMSC_SEL_NONE        2'h0
`define FMSC_SEL_LED1        2'h1
`define FMSC_SEL_LED2        2'h2
`define FMSC_SEL_LED3        2'h3
`define FMSC_LED_OFF         3'h0
`define FMSC_LED1            3'h1
`define FMSC_LED2            3'h2
`define FMSC_LED3            3'h4

// ==========================================================
// timing
`define FMSC_CLK_NS          20
`define FMSC_PRE_STEP_NS     2000
`define FMSC_STEP_CYC        ((`FMSC_PRE_STEP_NS + `FMSC_CLK_NS - 1) / `FMSC_CLK_NS)
`define FMSC_DIV_W           7
`define FMSC_TALLY_W         8
`define FMSC_TALLY_MAX       8'hFF

`endif

/* File: fmsc_host_model.sv */
/*
 * host side model: drives the register port of the float configuration bank
 * with one-cycle write and read strobes, and composes the words it writes.
 * assumes the bank takes a strobe at the rising edge and answers a read one
 * cycle later.
 */
`timescale 1ns/1ps
`include "fmsc_defines.svh"

module fmsc_host_model
    import fmsc_pkg::*;
(
    // clock
    input  wire logic                      core_clk_i,
    // register port
    output logic [`FMSC_ADDR_W-1:0]        reg_addr_o,
    output logic [`FMSC_DATA_W-1:0]        reg_wdata_o,
    output logic                           reg_wr_o,
    output logic                           reg_rd_o,
    input  wire logic [`FMSC_DATA_W-1:0]   reg_rdata_i
);
    initial begin
        reg_addr_o  = 8'h00;
        reg_wdata_o = 16'h0000;
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
    end

    // ==========================================================
    // raw accesses
    task automatic wr_raw(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk_i);
        reg_addr_o  <= a;
        reg_wdata_o <= d;
        reg_wr_o    <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_o    <= 1'b0;
    endtask

    // read data is registered, so it is taken one edge after the strobe
    task automatic rd_raw(input logic [7:0] a, output logic [15:0] d);
        @(posedge core_clk_i);
        reg_addr_o <= a;
        reg_rd_o   <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_o   <= 1'b0;
        @(posedge core_clk_i);
        #1;
        d = reg_rdata_i;
    endtask

    // ==========================================================
    // composed writes: reserved fields always get their fixed values
    task automatic wr_cfg(input logic [7:0] a, input logic [1:0] en, input logic [4:0] pre);
        wr_raw(a, {1'b0, en, pre, 8'h08});
    endtask

    task automatic wr_fire(input logic [3:0] pat_b, input logic [3:0] pat_a);
        wr_raw(`FMSC_OFF_FIRE, {pat_b, pat_a, 8'h10});
    endtask
endmodule // fmsc_host_model

/* File: fmsc_pkg.sv */
/*
 * types and shared decode functions of the float mode slot configuration.
 * assumes fmsc_defines.svh is on the include path.
 */
`include "fmsc_defines.svh"

package fmsc_pkg;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic [1:0] enable;
        logic [4:0] precon;
        logic [3:0] fire;
    } fmsc_slot_cfg_t;

    typedef struct packed {
        logic start;
        logic finish;
        logic pulse;
        logic subtract;
    } fmsc_slot_evt_t;

    typedef enum logic [2:0] {
        FMSC_IDLE   = 3'b001,
        FMSC_PRECON = 3'b010,
        FMSC_FLOAT  = 3'b100
    } fmsc_state_t;

    // ==========================================================
    // decode functions
    function automatic logic fmsc_float_on(input logic [1:0] en);
        return en == `FMSC_EN_ON;
    endfunction

    function automatic logic [2:0] fmsc_led_decode(input logic [1:0] sel);
        logic [2:0] led;
        led = `FMSC_LED_OFF;
        unique case (sel)
            `FMSC_SEL_NONE: led = `FMSC_LED_OFF;
            `FMSC_SEL_LED1: led = `FMSC_LED1;
            `FMSC_SEL_LED2: led = `FMSC_LED2;
            `FMSC_SEL_LED3: led = `FMSC_LED3;
        endcase
        return led;
    endfunction

endpackage

/* File: fmsc_slot.sv */
/*
 * one time slot of the float sequence: preconditioning delay, pulse
 * position in the group of four, fire/mask, emitter drive, background tally.
 * assumes events come from the sequencer on the same clock.
 */
`timescale 1ns/1ps
`include "fmsc_defines.svh"

module fmsc_slot
    import fmsc_pkg::*;
(
    // clock and reset
    input  wire logic                      core_clk_i,
    input  wire logic                      resetn_i,
    // configuration
    input  wire fmsc_slot_cfg_t            cfg_i,
    input  wire logic [1:0]                emitter_choice_i,
    input  wire logic [13:0]               background_limit_i,
    input  wire logic                      step_i,
    // sequencer events
    input  wire fmsc_slot_evt_t            evt_i,
    input  wire logic [13:0]               adc_i,
    // status
    output logic                           active_o,
    output logic                           interval_start_o,
    output logic [1:0]                     pos_o,
    output logic                           fire_o,
    output logic [2:0]                     led_o,
    output logic [`FMSC_TALLY_W-1:0]       tally_o
);

    // ==========================================================
    // state
    fmsc_state_t               state_r, state_nxt;
    logic [4:0]                cnt_r;
    logic [1:0]                pos_r;
    logic                      start_r;
    logic                      fire_r;
    logic [2:0]                led_r;
    logic [`FMSC_TALLY_W-1:0]  tally_r;

    wire  enabled   = fmsc_float_on(cfg_i.enable);
    wire  in_float  = state_r == FMSC_FLOAT;
    wire  cnt_zero  = cnt_r == 5'h00;
    wire  fire_now  = in_float & evt_i.pulse & ~cfg_i.fire[pos_r];
    wire  over_lim  = in_float & evt_i.subtract & (adc_i > background_limit_i);
    wire  tally_top = tally_r == `FMSC_TALLY_MAX;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            FMSC_IDLE:   if (evt_i.start && enabled) state_nxt = FMSC_PRECON;
            FMSC_PRECON: if (evt_i.finish) state_nxt = FMSC_IDLE;
                         else if (cnt_zero) state_nxt = FMSC_FLOAT;
            FMSC_FLOAT:  if (evt_i.finish) state_nxt = FMSC_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r <= FMSC_IDLE;
            cnt_r   <= 5'h00;
            start_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            start_r <= (state_r == FMSC_PRECON) && (state_nxt == FMSC_FLOAT);
            // one step of the free divider per count: first step may be short
            if (evt_i.start) cnt_r <= cfg_i.precon;
            else if (state_r == FMSC_PRECON && step_i && !cnt_zero) cnt_r <= cnt_r - 5'h01;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pos_r   <= 2'h0;
            fire_r  <= 1'b0;
            led_r   <= `FMSC_LED_OFF;
            tally_r <= '0;
        end else begin
            // two-bit counter wraps so every group of four reuses the pattern
            if (evt_i.start) pos_r <= 2'h0;
            else if (in_float && evt_i.pulse) pos_r <= pos_r + 2'h1;
            fire_r <= fire_now;
            led_r  <= fire_now ? fmsc_led_decode(emitter_choice_i) : `FMSC_LED_OFF;
            if (evt_i.start) tally_r <= '0;
            else if (over_lim && !tally_top) tally_r <= tally_r + 8'h01;
        end
    end

    assign active_o         = in_float;
    assign interval_start_o = start_r;
    assign pos_o            = pos_r;
    assign fire_o           = fire_r;
    assign led_o            = led_r;
    assign tally_o          = tally_r;

endmodule // fmsc_slot

/* File: fmsc_tb.sv */
/*
 * self-checking bench of the float configuration bank: register tasks via
 * the host model, sequencer events driven here on the rising edge.
 * assumes a 50 MHz clock and the divider step of 100 cycles.
 */
`timescale 1ns/1ps
`include "fmsc_defines.svh"

module testbench;
    import fmsc_pkg::*;

    logic                      core_clk_i = 1'b0;
    logic                      resetn_i   = 1'b0;
    logic [7:0]                reg_addr;
    logic [15:0]               reg_wdata;
    logic                      reg_wr;
    logic                      reg_rd;
    logic [15:0]               reg_rdata_o;
    logic [1:0]                choice     = 2'h0;
    logic [13:0]               adc        = 14'h0000;
    logic [13:0]               limit      = 14'h0064;
    fmsc_slot_evt_t            evt_a      = '0;
    fmsc_slot_evt_t            evt_b      = '0;
    logic                      active_a_o, interval_start_a_o, fire_a_o;
    logic                      active_b_o, interval_start_b_o, fire_b_o;
    logic [2:0]                led_a_o, led_b_o;
    logic [7:0]                tally_a_o, tally_b_o;
    logic [15:0]               d;
    int                        errors     = 0;
    int                        n_tests    = 0;

    always #10 core_clk_i = ~core_clk_i;

    fmsc_host_model u_host (.core_clk_i(core_clk_i), .reg_addr_o(reg_addr),
        .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
        .reg_rdata_i(reg_rdata_o));

    fmsc_top u_dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_rdata_o(reg_rdata_o), .float_emitter_choice_first_slot_i(choice),
        .float_emitter_choice_second_slot_i(choice),
        .background_limit_first_slot_i(limit), .background_limit_second_slot_i(limit),
        .evt_a_i(evt_a), .evt_b_i(evt_b), .adc_i(adc), .active_a_o(active_a_o),
        .interval_start_a_o(interval_start_a_o), .fire_a_o(fire_a_o), .led_a_o(led_a_o),
        .tally_a_o(tally_a_o), .active_b_o(active_b_o),
        .interval_start_b_o(interval_start_b_o), .fire_b_o(fire_b_o), .led_b_o(led_b_o),
        .background_tally_second_slot_o(tally_b_o));

    // ==========================================================
    // compare and closing
    task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        chk_word(what, {15'h0000, exp}, {15'h0000, got});
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ==========================================================
    // sequencer event tasks
    task automatic start_slot(input logic s, input int lo, input int hi);
        int n;
        logic ok;
        @(posedge core_clk_i);
        if (s) evt_b.start <= 1'b1; else evt_a.start <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk_i);
            evt_a.start <= 1'b0;
            evt_b.start <= 1'b0;
            n++;
            #1;
        end while (((s ? interval_start_b_o : interval_start_a_o) !== 1'b1) && n < 400);
        ok = (n >= lo) && (n <= hi);
        chk_bit("interval_start_window", 1'b1, ok);
        chk_bit("active", 1'b1, s ? active_b_o : active_a_o);
    endtask

    // back to back pulses; emitter choice follows the pulse index
    task automatic pulses(input logic s, input logic [3:0] pat);
        int j;
        logic [2:0] exp_l;
        for (int k = 0; k <= 8; k++) begin
            @(posedge core_clk_i);
            if (k < 8) begin
                if (s) evt_b.pulse <= 1'b1; else evt_a.pulse <= 1'b1;
                choice <= k[1:0];
            end else begin
                evt_a.pulse <= 1'b0;
                evt_b.pulse <= 1'b0;
            end
            if (k > 0) begin
                #1;
                j = (k - 1) % 4;
                exp_l = (!pat[j] && j != 0) ? (3'h1 << (j - 1)) : 3'h0;
                chk_bit("fire", ~pat[j], s ? fire_b_o : fire_a_o);
                chk_word("led", {13'h0000, exp_l}, {13'h0000, s ? led_b_o : led_a_o});
            end
        end
    endtask

    task automatic subtract(input logic s, input logic [13:0] v, input logic [7:0] exp);
        @(posedge core_clk_i);
        if (s) evt_b.subtract <= 1'b1; else evt_a.subtract <= 1'b1;
        adc <= v;
        @(posedge core_clk_i);
        evt_a.subtract <= 1'b0;
        evt_b.subtract <= 1'b0;
        #1;
        chk_word(s ? "tally_b" : "tally_a", {8'h00, exp}, {8'h00, s ? tally_b_o : tally_a_o});
    endtask

    task automatic finish_both();
        @(posedge core_clk_i);
        evt_a.finish <= 1'b1;
        evt_b.finish <= 1'b1;
        @(posedge core_clk_i);
        evt_a.finish <= 1'b0;
        evt_b.finish <= 1'b0;
        @(posedge core_clk_i);
        #1;
        chk_bit("active_a_idle", 1'b0, active_a_o);
        chk_bit("active_b_idle", 1'b0, active_b_o);
    endtask

    // ==========================================================
    // tests
    initial begin
        repeat (10) @(posedge core_clk_i);
        resetn_i <= 1'b1;

        u_host.rd_raw(`FMSC_OFF_CFG_B, d); chk_word("cfg_b_reset", 16'h0808, d);
        u_host.rd_raw(`FMSC_OFF_FIRE, d);  chk_word("fire_reset", 16'h0010, d);
        u_host.rd_raw(`FMSC_OFF_CFG_A, d); chk_word("cfg_a_reset", 16'h0808, d);
        u_host.wr_raw(8'h5B, 16'hFFFF);
        u_host.rd_raw(8'h5B, d);           chk_word("unmapped", 16'h0000, d);
        $display("test reset values done");

        u_host.wr_fire(4'h5, 4'hA);
        u_host.rd_raw(`FMSC_OFF_FIRE, d);  chk_word("fire_rw", 16'h5A10, d);
        u_host.wr_cfg(`FMSC_OFF_CFG_A, 2'h3, 5'h1F);
        u_host.rd_raw(`FMSC_OFF_CFG_A, d); chk_word("cfg_a_rw", 16'h7F08, d);
        $display("test readback done");

        for (int en = 0; en < 4; en++) begin
            u_host.wr_cfg(`FMSC_OFF_CFG_B, en[1:0], 5'h00);
            u_host.wr_cfg(`FMSC_OFF_CFG_A, en[1:0], 5'h00);
            @(posedge core_clk_i);
            evt_a.start <= 1'b1;
            evt_b.start <= 1'b1;
            @(posedge core_clk_i);
            evt_a.start <= 1'b0;
            evt_b.start <= 1'b0;
            repeat (3) @(posedge core_clk_i);
            #1;
            chk_bit("enable_b", en == 3, active_b_o);
            chk_bit("enable_a", en == 3, active_a_o);
            finish_both();
        end
        $display("test enable codes done");

        u_host.wr_cfg(`FMSC_OFF_CFG_B, 2'h3, 5'h00);
        start_slot(1'b1, 2, 2);
        pulses(1'b1, 4'h5);
        subtract(1'b1, 14'h0065, 8'h01);
        subtract(1'b1, 14'h0064, 8'h01);
        subtract(1'b1, 14'h00C8, 8'h02);
        // a start while floating keeps the state, so return to idle first
        finish_both();
        start_slot(1'b1, 2, 2);
        chk_word("tally_b_cleared", 16'h0000, {8'h00, tally_b_o});
        finish_both();
        $display("test second slot done");

        // first divider tick may come early, hence the one-step margin
        u_host.wr_cfg(`FMSC_OFF_CFG_A, 2'h3, 5'h02);
        start_slot(1'b0, 102, 202);
        pulses(1'b0, 4'hA);
        @(posedge core_clk_i);
        limit <= 14'h0020;
        subtract(1'b0, 14'h0021, 8'h01);
        subtract(1'b0, 14'h0020, 8'h01);
        finish_both();
        $display("test first slot done");
        end_sim();
    end

    initial begin
        #200000;
        errors++;
        end_sim();
    end
endmodule // testbench

/* File: fmsc_top.sv */
/*
 * float mode slot configuration bank: three 16-bit registers on the
 * device register port, a preconditioning step divider and two slots.
 * assumes the serial port decoder delivers one-cycle write and read
 * strobes on the sequencing clock.
 */
`timescale 1ns/1ps
`include "fmsc_defines.svh"

module fmsc_top
    import fmsc_pkg::*;
(
    // clock and reset
    input  wire logic                      core_clk_i,
    input  wire logic                      resetn_i,
    // register port
    input  wire logic [`FMSC_ADDR_W-1:0]   reg_addr_i,
    input  wire logic [`FMSC_DATA_W-1:0]   reg_wdata_i,
    input  wire logic                      reg_wr_i,
    input  wire logic                      reg_rd_i,
    output logic [`FMSC_DATA_W-1:0]        reg_rdata_o,
    // neighbouring configuration
    input  wire logic [1:0]                float_emitter_choice_first_slot_i,
    input  wire logic [1:0]                float_emitter_choice_second_slot_i,
    input  wire logic [13:0]               background_limit_first_slot_i,
    input  wire logic [13:0]               background_limit_second_slot_i,
    // sequencer events
    input  wire fmsc_slot_evt_t            evt_a_i,
    input  wire fmsc_slot_evt_t            evt_b_i,
    input  wire logic [13:0]               adc_i,
    // first slot status
    output logic                           active_a_o,
    output logic                           interval_start_a_o,
    output logic                           fire_a_o,
    output logic [2:0]                     led_a_o,
    output logic [`FMSC_TALLY_W-1:0]       tally_a_o,
    // second slot status
    output logic                           active_b_o,
    output logic                           interval_start_b_o,
    output logic                           fire_b_o,
    output logic [2:0]                     led_b_o,
    output logic [`FMSC_TALLY_W-1:0]       background_tally_second_slot_o
);

    // ==========================================================
    // register bank
    logic [`FMSC_DATA_W-1:0]   cfg_b_r;
    logic [`FMSC_DATA_W-1:0]   fire_r;
    logic [`FMSC_DATA_W-1:0]   cfg_a_r;
    logic [`FMSC_DATA_W-1:0]   rdata_r;

    wire  hit_b    = reg_addr_i == `FMSC_OFF_CFG_B;
    wire  hit_fire = reg_addr_i == `FMSC_OFF_FIRE;
    wire  hit_a    = reg_addr_i == `FMSC_OFF_CFG_A;
    // reserved bits are stored as written; the host keeps them at their fixed values
    wire  [`FMSC_DATA_W-1:0] rd_mux = hit_b    ? cfg_b_r :
                                      hit_fire ? fire_r  :
                                      hit_a    ? cfg_a_r : `FMSC_RDATA_IDLE;

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cfg_b_r <= `FMSC_RST_CFG;
            fire_r  <= `FMSC_RST_FIRE;
            cfg_a_r <= `FMSC_RST_CFG;
            rdata_r <= `FMSC_RDATA_IDLE;
        end else begin
            if (reg_wr_i && hit_b) cfg_b_r <= reg_wdata_i;
            if (reg_wr_i && hit_fire) fire_r <= reg_wdata_i;
            if (reg_wr_i && hit_a) cfg_a_r <= reg_wdata_i;
            if (reg_rd_i) rdata_r <= rd_mux;
        end
    end

    assign reg_rdata_o = rdata_r;

    // ==========================================================
    // field extraction
    fmsc_slot_cfg_t cfg_a, cfg_b;

    assign cfg_a.enable = cfg_a_r[`FMSC_EN_MSB:`FMSC_EN_LSB];
    assign cfg_a.precon = cfg_a_r[`FMSC_PRE_MSB:`FMSC_PRE_LSB];
    assign cfg_a.fire   = fire_r[`FMSC_FIRE_A_MSB:`FMSC_FIRE_A_LSB];
    assign cfg_b.enable = cfg_b_r[`FMSC_EN_MSB:`FMSC_EN_LSB];
    assign cfg_b.precon = cfg_b_r[`FMSC_PRE_MSB:`FMSC_PRE_LSB];
    assign cfg_b.fire   = fire_r[`FMSC_FIRE_B_MSB:`FMSC_FIRE_B_LSB];

    // ==========================================================
    // precondition step divider, 2 us per count
    logic [`FMSC_DIV_W-1:0] div_r;
    wire  div_end = div_r == `FMSC_DIV_W'(`FMSC_STEP_CYC - 1);

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) div_r <= '0;
        else div_r <= div_end ? '0 : div_r + `FMSC_DIV_W'(1);
    end

    // ==========================================================
    // slots
    logic [1:0] pos_a, pos_b;

    fmsc_slot u_slot_a (
        .core_clk_i         (core_clk_i),
        .resetn_i           (resetn_i),
        .cfg_i              (cfg_a),
        .emitter_choice_i   (float_emitter_choice_first_slot_i),
        .background_limit_i (background_limit_first_slot_i),
        .step_i             (div_end),
        .evt_i              (evt_a_i),
        .adc_i              (adc_i),
        .active_o           (active_a_o),
        .interval_start_o   (interval_start_a_o),
        .pos_o              (pos_a),
        .fire_o             (fire_a_o),
        .led_o              (led_a_o),
        .tally_o            (tally_a_o)
    );

    fmsc_slot u_slot_b (
        .core_clk_i         (core_clk_i),
        .resetn_i           (resetn_i),
        .cfg_i              (cfg_b),
        .emitter_choice_i   (float_emitter_choice_second_slot_i),
        .background_limit_i (background_limit_second_slot_i),
        .step_i             (div_end),
        .evt_i              (evt_b_i),
        .adc_i              (adc_i),
        .active_o           (active_b_o),
        .interval_start_o   (interval_start_b_o),
        .pos_o              (pos_b),
        .fire_o             (fire_b_o),
        .led_o              (led_b_o),
        .tally_o            (background_tally_second_slot_o)
    );

    // ==========================================================
    // checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);

    // precondition wait measured from entry into the delay
    logic [11:0] wait_r;
    logic        pre_b_r;
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wait_r  <= '0;
            pre_b_r <= 1'b0;
        end else begin
            pre_b_r <= pre_b_r ? !(evt_b_i.finish || active_b_o) :
                       (evt_b_i.start && !active_b_o && fmsc_float_on(cfg_b.enable));
            wait_r  <= (evt_b_i.start && !active_b_o) ? 12'h000 : wait_r + 12'h001;
        end
    end

    sequence s_pulse_b;
        active_b_o && !evt_b_i.finish && evt_b_i.pulse;
    endsequence

    sequence s_pulse_a;
        active_a_o && !evt_a_i.finish && evt_a_i.pulse;
    endsequence

    a_cfg_write_b: assert property (reg_wr_i && hit_b |=> cfg_b_r == $past(reg_wdata_i))
        else $error("second slot config write lost");
    a_read_back: assert property (reg_rd_i && hit_fire && !reg_wr_i ##1 1'b1
        |-> reg_rdata_o == fire_r)
        else $error("pattern read back wrong");
    a_reserved_b_off: assert property (evt_b_i.start && !fmsc_float_on(cfg_b.enable)
        && !active_b_o && !pre_b_r |=> !active_b_o [*3])
        else $error("second slot float entered while disabled");
    a_reserved_a_off: assert property (evt_a_i.start && !fmsc_float_on(cfg_a.enable)
        && !active_a_o |=> !interval_start_a_o [*3])
        else $error("first slot interval began while disabled");
    a_precon_bound: assert property (interval_start_b_o |->
        int'(wait_r) <= int'($past(cfg_b.precon)) * `FMSC_STEP_CYC + 4)
        else $error("second slot precondition too long");
    a_fire_map_b: assert property (s_pulse_b |=>
        fire_b_o == !$past(cfg_b.fire[pos_b]))
        else $error("second slot fire mask wrong");
    a_fire_map_a: assert property (s_pulse_a |=>
        fire_a_o == !$past(cfg_a.fire[pos_a]))
        else $error("first slot fire mask wrong");
    a_group_wrap: assert property (s_pulse_b and (pos_b == 2'h3 && !evt_b_i.start)
        |=> pos_b == 2'h0)
        else $error("pulse group did not wrap");
    a_emitter_drv: assert property (fire_b_o |->
        led_b_o == fmsc_led_decode($past(float_emitter_choice_second_slot_i)))
        else $error("emitter decode wrong");
    a_dark_drv: assert property (!fire_a_o |-> led_a_o == `FMSC_LED_OFF)
        else $error("emitter driven while masked");
    a_tally_step: assert property (active_b_o && evt_b_i.subtract && !evt_b_i.start
        && !evt_b_i.finish && adc_i > background_limit_second_slot_i
        && background_tally_second_slot_o != `FMSC_TALLY_MAX
        |=> background_tally_second_slot_o == $past(background_tally_second_slot_o) + 8'h01)
        else $error("background tally missed");
    a_cfg_write_a: assert property (reg_wr_i && hit_a |=> cfg_a_r == $past(reg_wdata_i))
        else $error("first slot config write lost");
    a_group_wrap_a: assert property (s_pulse_a and (pos_a == 2'h3 && !evt_a_i.start)
        |=> pos_a == 2'h0)
        else $error("first slot pulse group did not wrap");
    a_emitter_drv_a: assert property (fire_a_o |->
        led_a_o == fmsc_led_decode($past(float_emitter_choice_first_slot_i)))
        else $error("first slot emitter decode wrong");
    a_dark_drv_b: assert property (!fire_b_o |-> led_b_o == `FMSC_LED_OFF)
        else $error("second slot emitter driven while masked");
    a_tally_step_a: assert property (active_a_o && evt_a_i.subtract && !evt_a_i.start
        && !evt_a_i.finish && adc_i > background_limit_first_slot_i
        && tally_a_o != `FMSC_TALLY_MAX
        |=> tally_a_o == $past(tally_a_o) + 8'h01)
        else $error("first slot background tally missed");

endmodule // fmsc_top
